//--- logic/ast_pkg.sv
// Package of constants and types for the asynchronous serial transmitter
package ast_pkg;

	// ------------------------------------------------------------
	// Register indexes (one 8-bit register per address)
	// ------------------------------------------------------------
	localparam logic [3:0] AST_REG_TX_CTRL    = 4'h0;
	localparam logic [3:0] AST_REG_HOLD       = 4'h1;
	localparam logic [3:0] AST_REG_BAUD_CTRL  = 4'h2;
	localparam logic [3:0] AST_REG_PORT_CTRL  = 4'h3;
	localparam logic [3:0] AST_REG_FLAG       = 4'h4;
	localparam logic [3:0] AST_REG_IRQ_ENABLE = 4'h5;
	localparam logic [3:0] AST_REG_EVT_STATUS = 4'h6;
	localparam logic [3:0] AST_REG_EVT_MASK   = 4'h7;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int AST_BIT_NINE_BIT   = 6;
	localparam int AST_BIT_TX_ON      = 5;
	localparam int AST_BIT_SYNC_MODE  = 4;
	localparam int AST_BIT_TWO_STOP   = 3;
	localparam int AST_BIT_SHIFT_EMPT = 1;
	localparam int AST_BIT_NINTH_DATA = 0;
	localparam int AST_BIT_INVERT     = 4;
	localparam int AST_BIT_PORT_EN    = 7;
	localparam int AST_BIT_READY      = 4;
	localparam int AST_BIT_READY_IE   = 4;
	localparam int AST_EVT_FRAME_DONE = 0;
	localparam int AST_EVT_CHAR_LOAD  = 1;

	// ------------------------------------------------------------
	// Reset values and frame sizes
	// ------------------------------------------------------------
	localparam logic       AST_RST_CTRL_BIT  = 1'b0;
	localparam logic [7:0] AST_RST_BYTE      = 8'h00;
	localparam logic [1:0] AST_RST_EVT       = 2'h0;
	localparam logic       AST_RST_LINE      = 1'b1;
	localparam logic [3:0] AST_FRAME_BASE    = 4'ha;
	localparam logic [3:0] AST_REMAIN_LAST   = 4'h1;
	localparam logic [3:0] AST_REMAIN_NONE   = 4'h0;
	localparam logic [11:0] AST_SHIFT_IDLE   = 12'hfff;

	// ------------------------------------------------------------
	// State records
	// ------------------------------------------------------------
	typedef struct packed {
		logic       nineBit;
		logic       transmitterOn;
		logic       syncMode;
		logic       twoStop;
		logic       ninthData;
		logic       invertSel;
		logic       portEnable;
		logic       readyIrqEnable;
		logic [7:0] hold;
		logic       holdFull;
		logic       load;
		logic       readyFlag;
		logic [1:0] evtStatus;
		logic [1:0] evtMask;
		logic [7:0] rdData;
	} ast_ctrl_state_t;

	typedef struct packed {
		logic [11:0] shreg;
		logic [3:0]  remain;
		logic        busy;
		logic        inv;
		logic        line;
	} ast_shift_state_t;

endpackage

//--- logic/ast_shift_if.sv
// Interface between the transmitter control and its shift register
interface ast_shift_if;
	logic       load;
	logic [8:0] loadData;
	logic       nineBit;
	logic       twoStop;
	logic       invert;
	logic       abort;
	logic       busy;
	logic       line;
	logic       frameEnd;

	modport ctrl (
		output load,
		output loadData,
		output nineBit,
		output twoStop,
		output invert,
		output abort,
		input  busy,
		input  line,
		input  frameEnd
	);

	modport shifter (
		input  load,
		input  loadData,
		input  nineBit,
		input  twoStop,
		input  invert,
		input  abort,
		output busy,
		output line,
		output frameEnd
	);
endinterface

//--- logic/ast_shifter.sv
// Shift register that frames and sends one character per load
module ast_shifter
	import ast_pkg::*;
(
	input  wire logic   core_clk,
	input  wire logic   srst,
	input  wire logic   baudTick,
	ast_shift_if.shifter sh
);

	ast_shift_state_t state;
	ast_shift_state_t next_state;

	// ------------------------------------------------------------
	// Framing and shifting
	// ------------------------------------------------------------
	// Frame is built once at load; shifting fills with mark so stop bits fall out for free
	always_comb begin
		next_state = state;
		next_state.inv = sh.invert;
		if (sh.abort) begin
			next_state.busy = 1'b0;
			next_state.remain = AST_REMAIN_NONE;
			next_state.shreg = AST_SHIFT_IDLE;
		end else if (sh.load && !state.busy) begin
			next_state.shreg = {2'b11, sh.nineBit ? sh.loadData[8] : 1'b1, sh.loadData[7:0], 1'b0}; // [R11]
			next_state.remain = AST_FRAME_BASE + {3'b000, sh.nineBit} + {3'b000, sh.twoStop};
			next_state.busy = 1'b1;
		end else if (state.busy && baudTick) begin
			next_state.shreg = {1'b1, state.shreg[11:1]}; // [R12] [R15]
			next_state.remain = state.remain - AST_REMAIN_LAST;
			if (state.remain == AST_REMAIN_LAST) begin
				next_state.busy = 1'b0;
			end
		end
		// Idle rests at mark before polarity is applied
		next_state.line = (next_state.busy ? next_state.shreg[0] : 1'b1) ^ next_state.inv; // [R14] [R4]
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state.shreg <= AST_SHIFT_IDLE;
			state.remain <= AST_REMAIN_NONE;
			state.busy <= AST_RST_CTRL_BIT;
			state.inv <= AST_RST_CTRL_BIT;
			state.line <= AST_RST_LINE;
		end else begin
			state <= next_state;
		end
	end

	// Outputs toward control
	assign sh.busy = state.busy;
	assign sh.line = state.line;
	assign sh.frameEnd = state.busy && baudTick && !sh.abort && (state.remain == AST_REMAIN_LAST);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_idle_mark: assert property (@(posedge core_clk) disable iff (srst) // [R14]
		!state.busy |-> state.line == !state.inv)
		else $error("idle line not at mark");

	a_start_space: assert property (@(posedge core_clk) disable iff (srst) // [R11]
		(sh.load && !state.busy && !sh.abort) |=> (state.busy && state.line == state.inv))
		else $error("start bit not at space");

	a_lsb_shift: assert property (@(posedge core_clk) disable iff (srst) // [R12]
		(state.busy && baudTick && !sh.abort && state.remain != AST_REMAIN_LAST)
		|=> state.line == ($past(state.shreg[1]) ^ state.inv))
		else $error("bit order wrong");

	a_tick_paced: assert property (@(posedge core_clk) disable iff (srst) // [R15]
		(state.busy && !baudTick && !sh.abort && !sh.load) |=> $stable(state.shreg))
		else $error("shift without baud tick");

endmodule

//--- logic/ast_tx.sv
// Top of the asynchronous serial transmitter: registers, holding stage, interrupt
//
// Operation
// R1 - Write into idle path moves straight to shifter
// R2 - Busy shifter keeps new character in holding
// R3 - Pending character moves one cycle after stop
// R4 - Invert select flips idle and data polarity
// R5 - Inversion acts only in asynchronous mode
// R6 - Ready high unless busy with character waiting; here also held low while the transmitter is off
// R7 - Ready flag valid second cycle after write
// R8 - Ready flag is read-only, derived from holding
// R9 - Interrupt needs ready flag and enable both; here irq also rises on any event set in both evtStatus and evtMask
// R10 - Software enables interrupt only while data remains
// R11 - Frame: start, eight/nine data, stop bits
// R12 - Data bits go out LSb first
// R13 - Active only when on, async, port enabled
// R14 - Line rests at mark between characters
// R15 - One bit shifted per baud tick
//
// Decided for this implementation: the register offsets and strobed register access.
module ast_tx
	import ast_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       srst,
	input  wire logic [3:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWrite,
	input  wire logic       regRead,
	output logic      [7:0] regRdData,
	input  wire logic       baudTick,
	output logic            txPin,
	output logic            txPinOe,
	output logic            irq
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// One decode shared by every write select; reads decode regAddr in a case
	function automatic logic astHit(input logic strobe, input logic [3:0] addr, input logic [3:0] idx);
		astHit = strobe && (addr == idx);
	endfunction

	ast_ctrl_state_t state;
	ast_ctrl_state_t next_state;
	ast_shift_if     sh ();

	logic txActive;
	logic [1:0] evtSet;
	logic wrHold;

	// ------------------------------------------------------------
	// Shift register instance
	// ------------------------------------------------------------
	ast_shifter u_shifter (
		.core_clk (core_clk),
		.srst     (srst),
		.baudTick (baudTick),
		.sh       (sh.shifter)
	);

	// Mode gating of the whole transmit path
	assign txActive = state.transmitterOn && !state.syncMode && state.portEnable; // [R13]
	assign wrHold = astHit(regWrite, regAddr, AST_REG_HOLD);

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		evtSet = 2'b00;

		// Configuration writes
		if (astHit(regWrite, regAddr, AST_REG_TX_CTRL)) begin
			next_state.nineBit = regWrData[AST_BIT_NINE_BIT];
			next_state.transmitterOn = regWrData[AST_BIT_TX_ON];
			next_state.syncMode = regWrData[AST_BIT_SYNC_MODE];
			next_state.twoStop = regWrData[AST_BIT_TWO_STOP];
			next_state.ninthData = regWrData[AST_BIT_NINTH_DATA];
		end
		if (astHit(regWrite, regAddr, AST_REG_BAUD_CTRL)) begin
			next_state.invertSel = regWrData[AST_BIT_INVERT];
		end
		if (astHit(regWrite, regAddr, AST_REG_PORT_CTRL)) begin
			next_state.portEnable = regWrData[AST_BIT_PORT_EN];
		end
		if (astHit(regWrite, regAddr, AST_REG_IRQ_ENABLE)) begin
			next_state.readyIrqEnable = regWrData[AST_BIT_READY_IE];
		end
		if (astHit(regWrite, regAddr, AST_REG_EVT_MASK)) begin
			next_state.evtMask = regWrData[1:0];
		end

		// Holding stage: one entry; a write onto a full entry is dropped, software must poll ready
		next_state.load = 1'b0;
		if (state.load) begin
			next_state.holdFull = 1'b0;
		end
		if (txActive && state.holdFull && !sh.busy && !state.load) begin // [R2]
			next_state.load = 1'b1; // [R1] [R3]
		end
		// Entry moving out this cycle is free already, as the ready flag has told software
		if (wrHold && (!state.holdFull || state.load)) begin
			next_state.hold = regWrData;
			next_state.holdFull = 1'b1; // [R1]
		end
		// Switching the transmitter off flushes any queued character
		if (!state.transmitterOn) begin
			next_state.holdFull = 1'b0;
			next_state.load = 1'b0;
		end

		// Ready tracks transmitter enable and occupancy; writes to its register have no effect
		next_state.readyFlag = state.transmitterOn && !(state.holdFull && (sh.busy || state.load)); // [R6] [R7] [R8]

		// Sticky events: set beats the write-one clear in the same cycle
		evtSet[AST_EVT_FRAME_DONE] = sh.frameEnd;
		evtSet[AST_EVT_CHAR_LOAD] = state.load;
		if (astHit(regWrite, regAddr, AST_REG_EVT_STATUS)) begin
			next_state.evtStatus = state.evtStatus & ~regWrData[1:0];
		end
		next_state.evtStatus = next_state.evtStatus | evtSet;

		// Read data stands in the cycle after the strobe only
		next_state.rdData = AST_RST_BYTE;
		if (regRead) begin
			unique case (regAddr)
				AST_REG_TX_CTRL: begin
					next_state.rdData[AST_BIT_NINE_BIT] = state.nineBit;
					next_state.rdData[AST_BIT_TX_ON] = state.transmitterOn;
					next_state.rdData[AST_BIT_SYNC_MODE] = state.syncMode;
					next_state.rdData[AST_BIT_TWO_STOP] = state.twoStop;
					next_state.rdData[AST_BIT_SHIFT_EMPT] = !sh.busy;
					next_state.rdData[AST_BIT_NINTH_DATA] = state.ninthData;
				end
				AST_REG_HOLD: begin
					next_state.rdData = state.hold;
				end
				AST_REG_BAUD_CTRL: begin
					next_state.rdData[AST_BIT_INVERT] = state.invertSel;
				end
				AST_REG_PORT_CTRL: begin
					next_state.rdData[AST_BIT_PORT_EN] = state.portEnable;
				end
				AST_REG_FLAG: begin
					next_state.rdData[AST_BIT_READY] = state.readyFlag;
				end
				AST_REG_IRQ_ENABLE: begin
					next_state.rdData[AST_BIT_READY_IE] = state.readyIrqEnable;
				end
				AST_REG_EVT_STATUS: begin
					next_state.rdData[1:0] = state.evtStatus;
				end
				AST_REG_EVT_MASK: begin
					next_state.rdData[1:0] = state.evtMask;
				end
				default: begin
					next_state.rdData = AST_RST_BYTE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state.nineBit <= AST_RST_CTRL_BIT;
			state.transmitterOn <= AST_RST_CTRL_BIT;
			state.syncMode <= AST_RST_CTRL_BIT;
			state.twoStop <= AST_RST_CTRL_BIT;
			state.ninthData <= AST_RST_CTRL_BIT;
			state.invertSel <= AST_RST_CTRL_BIT;
			state.portEnable <= AST_RST_CTRL_BIT;
			state.readyIrqEnable <= AST_RST_CTRL_BIT;
			state.hold <= AST_RST_BYTE;
			state.holdFull <= AST_RST_CTRL_BIT;
			state.load <= AST_RST_CTRL_BIT;
			state.readyFlag <= AST_RST_CTRL_BIT;
			state.evtStatus <= AST_RST_EVT;
			state.evtMask <= AST_RST_EVT;
			state.rdData <= AST_RST_BYTE;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// Connections and outputs
	// ------------------------------------------------------------
	// Shifter control; inversion means something else in clocked mode so it is masked there
	assign sh.load = state.load;
	assign sh.loadData = {state.ninthData, state.hold};
	assign sh.nineBit = state.nineBit;
	assign sh.twoStop = state.twoStop;
	assign sh.invert = state.invertSel && !state.syncMode; // [R5] [R4]
	assign sh.abort = !txActive; // [R13]

	// Pin and bus outputs
	assign txPin = sh.line;
	assign txPinOe = state.portEnable;
	assign regRdData = state.rdData;
	assign irq = (state.readyFlag && state.readyIrqEnable) || |(state.evtStatus & state.evtMask); // [R9]

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_queued;
		state.holdFull && sh.busy && txActive;
	endsequence

	sequence s_stop_done;
		sh.frameEnd ##1 !sh.busy;
	endsequence

	a_load_idle: assert property (@(posedge core_clk) disable iff (srst) // [R1]
		(wrHold && !state.holdFull && txActive && !sh.busy && !state.load) ##1 (txActive && !sh.busy)
		|=> state.load ##1 sh.busy)
		else $error("idle write did not reach shifter");

	a_hold_waits: assert property (@(posedge core_clk) disable iff (srst) // [R2]
		s_queued |=> (state.holdFull && !state.load))
		else $error("queued character left early");

	a_move_after_stop: assert property (@(posedge core_clk) disable iff (srst) // [R3]
		(s_queued ##0 sh.frameEnd) ##1 txActive |=> state.load ##1 (sh.busy && txPin == sh.invert))
		else $error("pending character not moved after stop");

	a_ready_low: assert property (@(posedge core_clk) disable iff (srst) // [R6]
		(state.holdFull && sh.busy && state.transmitterOn) |=> !state.readyFlag)
		else $error("ready high while character waits");

	a_ready_high: assert property (@(posedge core_clk) disable iff (srst) // [R6]
		(state.transmitterOn && !state.holdFull) |=> state.readyFlag)
		else $error("ready low with empty holding");

	a_ready_delay: assert property (@(posedge core_clk) disable iff (srst) // [R7]
		(wrHold && !state.holdFull && state.transmitterOn) ##1 (sh.busy && state.transmitterOn)
		|=> !state.readyFlag)
		else $error("ready not low by second cycle");

	a_flag_readonly: assert property (@(posedge core_clk) disable iff (srst) // [R8]
		(astHit(regWrite, regAddr, AST_REG_FLAG) && !state.transmitterOn) |=> !state.readyFlag)
		else $error("software changed ready flag");

	a_irq_gate: assert property (@(posedge core_clk) disable iff (srst) // [R9]
		(state.evtStatus & state.evtMask) == 2'b00 |-> irq == (state.readyFlag && state.readyIrqEnable))
		else $error("interrupt not gated by enable");

	a_inactive_idle: assert property (@(posedge core_clk) disable iff (srst) // [R13]
		!txActive |=> (!state.load ##1 !sh.busy))
		else $error("transmit while not active");

	a_evt_sticky: assert property (@(posedge core_clk) disable iff (srst) // [R3]
		s_stop_done |-> state.evtStatus[AST_EVT_FRAME_DONE])
		else $error("frame done event lost");

	a_sync_no_invert: assert property (@(posedge core_clk) disable iff (srst) // [R5]
		(state.syncMode && !sh.busy) ##1 (state.syncMode && !sh.busy) |-> txPin == 1'b1)
		else $error("inversion active in clocked mode");

endmodule

//--- verification/ast_line_monitor.sv
// Behavioural receiver that watches the serial line and collects characters
module ast_line_monitor
	import ast_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       srst,
	input  wire logic       baudTick,
	input  wire logic       txPin,
	input  wire logic       invert,
	input  wire logic       listen,
	output logic      [7:0] rxData,
	output logic      [7:0] rxCount,
	output logic      [7:0] rxBad
);
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------
	// Receiver state
	// ------------------------------------------------------------
	logic       inFrame;
	logic [3:0] idx;
	logic [8:0] bits;
	logic       lvl;

	// Undo the polarity the bench selected, so checks run on mark/space
	assign lvl = txPin ^ invert;

	// Sample each bit at the tick that ends it; same clock as the sender
	always_ff @(posedge core_clk) begin
		if (srst) begin
			inFrame <= 1'b0;
			idx     <= 4'h0;
			bits    <= 9'h000;
			rxData  <= 8'h00;
			rxCount <= 8'h00;
			rxBad   <= 8'h00;
		end else if (!listen) begin
			inFrame <= 1'b0; // Deaf while polarity changes, avoids false starts
		end else if (!inFrame) begin
			inFrame <= !lvl; // Idle is mark, a space opens a frame
			idx     <= (!lvl && baudTick) ? 4'h1 : 4'h0; // A start bit seen on its closing tick still counts
			bits[0] <= lvl;
		end else if (baudTick) begin
			idx <= idx + 4'h1; // One bit per tick period
			if (idx == 4'h9) begin
				inFrame <= 1'b0;
				rxCount <= rxCount + 8'h01;
				rxData  <= bits[8:1]; // First data bit seen is bit 0
				if (bits[0] || !lvl) begin
					rxBad <= rxBad + 8'h01; // Start must be space, stop mark
				end
			end else begin
				bits[idx] <= lvl;
			end
		end
	end
endmodule

//--- verification/async_serial_transmitter_test.sv
// Self-checking bench for the asynchronous serial transmitter
module async_serial_transmitter_test
	import ast_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------
	// Stimulus, clock and instances
	// ------------------------------------------------------------
	logic       core_clk  = 1'b0;
	logic       srst      = 1'b1;
	logic [3:0] regAddr   = 4'h0;
	logic [7:0] regWrData = 8'h00;
	logic       regWrite  = 1'b0;
	logic       regRead   = 1'b0;
	logic       baudTick  = 1'b0;
	logic       monInv    = 1'b0;
	logic       listen    = 1'b0;
	logic [2:0] tickDiv   = 3'h0;
	logic [7:0] regRdData, rxData, rxCount, rxBad, rdVal;
	logic       txPin, txPinOe, irq;
	int         errCount  = 0;
	int         testsRun  = 0;
	int         cycles    = 0;

	always #5 core_clk = ~core_clk;

	// Baud tick every eight clocks keeps frames short
	always @(posedge core_clk) begin
		tickDiv  <= tickDiv + 3'h1;
		baudTick <= (tickDiv == 3'h7);
	end

	ast_tx uut (.core_clk(core_clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .baudTick(baudTick),
		.txPin(txPin), .txPinOe(txPinOe), .irq(irq));

	ast_line_monitor mon (.core_clk(core_clk), .srst(srst), .baudTick(baudTick), .txPin(txPin),
		.invert(monInv), .listen(listen), .rxData(rxData), .rxCount(rxCount), .rxBad(rxBad));

	// ------------------------------------------------------------
	// Bus cycles and comparison
	// ------------------------------------------------------------
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		regAddr   <= a;
		regWrData <= d;
		regWrite  <= 1'b1;
		@(posedge core_clk);
		regWrite  <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge core_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge core_clk);
		regRead <= 1'b0;
		#1 rdVal = regRdData;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
		testsRun++;
		if (got !== exp) begin
			errCount++;
			$display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	// Bounded wait for the monitor to count a given number of characters
	task automatic waitCount(input logic [7:0] n);
		int k;
		for (k = 0; k < 400 && rxCount !== n; k++) @(posedge core_clk);
		check(rxCount, n, "frame count");
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic testReset;
		int a;
		for (a = 0; a < 9; a++) begin
			rd(4'(a));
			check(rdVal, (a == 0) ? 8'h02 : 8'h00, "reset value");
		end
		check({6'h00, txPin, txPinOe}, 8'h02, "idle pins");
		check({7'h00, irq}, 8'h00, "irq at reset");
	endtask

	task automatic testEnable;
		wr(AST_REG_PORT_CTRL, 8'h80);
		wr(AST_REG_TX_CTRL, 8'h20);
		rd(AST_REG_FLAG);
		check(rdVal, 8'h10, "ready after enable");
		check({7'h00, txPinOe}, 8'h01, "pin driven");
		wr(AST_REG_FLAG, 8'h00);
		rd(AST_REG_FLAG);
		check(rdVal, 8'h10, "flag read-only");
	endtask

	task automatic testQueue;
		listen = 1'b1;
		wr(AST_REG_HOLD, 8'h55);
		wr(AST_REG_HOLD, 8'ha3);
		rd(AST_REG_FLAG);
		check(rdVal, 8'h00, "ready low with queued char");
		wr(AST_REG_HOLD, 8'h3c);
		waitCount(8'h01);
		check(rxData, 8'h55, "first char");
		waitCount(8'h02);
		check(rxData, 8'ha3, "queued char");
		check(rxBad, 8'h00, "framing");
		rd(AST_REG_FLAG);
		check(rdVal, 8'h10, "ready after drain");
		repeat (120) @(posedge core_clk);
		check(rxCount, 8'h02, "write to full holding dropped");
	endtask

	task automatic testIrq;
		wr(AST_REG_IRQ_ENABLE, 8'h10);
		check({7'h00, irq}, 8'h01, "ready irq");
		wr(AST_REG_HOLD, 8'hf0);
		wr(AST_REG_IRQ_ENABLE, 8'h00); // Last char written, so enable goes off
		check({7'h00, irq}, 8'h00, "irq masked");
		wr(AST_REG_EVT_STATUS, 8'h03);
		waitCount(8'h03);
		check(rxData, 8'hf0, "third char");
		@(posedge core_clk);
		#1;
		rd(AST_REG_EVT_STATUS);
		check(rdVal, 8'h01, "frame done sticky");
		check({7'h00, irq}, 8'h00, "event masked");
		wr(AST_REG_EVT_MASK, 8'h01);
		check({7'h00, irq}, 8'h01, "event irq");
		wr(AST_REG_EVT_STATUS, 8'h01);
		check({7'h00, irq}, 8'h00, "event cleared");
	endtask

	task automatic testInvert;
		int k;
		int bad;
		listen = 1'b0;
		wr(AST_REG_BAUD_CTRL, 8'h10);
		repeat (3) @(posedge core_clk);
		check({7'h00, txPin}, 8'h00, "inverted idle");
		monInv = 1'b1;
		listen = 1'b1;
		wr(AST_REG_HOLD, 8'h0f);
		waitCount(8'h06);
		check(rxData, 8'h0f, "inverted char");
		listen = 1'b0;
		wr(AST_REG_TX_CTRL, 8'h30);
		repeat (3) @(posedge core_clk);
		check({7'h00, txPin}, 8'h01, "no inversion in sync mode");
		wr(AST_REG_HOLD, 8'h81);
		bad = 0;
		for (k = 0; k < 100; k++) begin
			@(posedge core_clk);
			bad += (txPin !== 1'b1);
		end
		check(8'(bad), 8'h00, "no frame in sync mode");
		wr(AST_REG_TX_CTRL, 8'h00);
	endtask

	// Nine data bits and two stop bits; the monitor reads the ninth bit as its stop bit
	task automatic testFrameOptions;
		wr(AST_REG_TX_CTRL, 8'h60);
		wr(AST_REG_HOLD, 8'hff);
		waitCount(8'h04);
		check(rxData, 8'hff, "nine-bit char");
		check(rxBad, 8'h01, "ninth bit sent as space");
		repeat (9) @(posedge core_clk);
		rd(AST_REG_TX_CTRL);
		check(rdVal, 8'h62, "one stop bit then empty");
		wr(AST_REG_TX_CTRL, 8'h69);
		wr(AST_REG_HOLD, 8'h5a);
		waitCount(8'h05);
		check(rxData, 8'h5a, "two-stop char");
		check(rxBad, 8'h01, "ninth bit sent as mark");
		repeat (9) @(posedge core_clk);
		rd(AST_REG_TX_CTRL);
		check(rdVal, 8'h69, "second stop bit on line");
		repeat (8) @(posedge core_clk);
		wr(AST_REG_TX_CTRL, 8'h20);
	endtask

	// ------------------------------------------------------------
	// Verdict, timeout and main sequence
	// ------------------------------------------------------------
	task automatic endOfTest;
		if (errCount == 0 && testsRun > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Whole run needs about 800 cycles; the ceiling leaves margin
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			errCount++;
			endOfTest();
		end
	end

	initial begin
		repeat (10) @(posedge core_clk);
		srst <= 1'b0;
		testReset();
		testEnable();
		testQueue();
		testIrq();
		testFrameOptions();
		testInvert();
		endOfTest();
	end
endmodule
